// file: shared/reload_timer_pkg.sv
package reload_timer_pkg;

  // ----------------------------------------------------------------
  // Counter geometry and reset values.
  // ----------------------------------------------------------------
  localparam int          COUNT_WIDTH   = 16;
  localparam logic [15:0] COUNT_RESET   = 16'h0000;
  localparam logic [15:0] COUNT_ZERO    = 16'h0000;
  localparam logic [15:0] RELOAD_RESET  = 16'h0000;

  // ----------------------------------------------------------------
  // Count clock choices: three internal divides and the event input.
  // ----------------------------------------------------------------
  localparam int          PRESCALE_WIDTH = 8;
  localparam logic [1:0]  CLKSEL_DIV_A   = 2'h0;
  localparam logic [1:0]  CLKSEL_DIV_B   = 2'h1;
  localparam logic [1:0]  CLKSEL_DIV_C   = 2'h2;
  localparam logic [1:0]  CLKSEL_EVENT   = 2'h3;

  // ----------------------------------------------------------------
  // Event edge selection.
  // ----------------------------------------------------------------
  localparam logic [1:0]  EDGE_NONE      = 2'h0;
  localparam logic [1:0]  EDGE_RISE      = 2'h1;
  localparam logic [1:0]  EDGE_FALL      = 2'h2;
  localparam logic [1:0]  EDGE_BOTH      = 2'h3;

  typedef enum logic [0:0] {
    MODE_ONE_SHOT,
    MODE_RELOAD
  } count_mode_t;

endpackage : reload_timer_pkg

// file: src/tick_source.sv
module tick_source
#(
  parameter int DIV_A_LOG2 = 1,
  parameter int DIV_B_LOG2 = 3,
  parameter int DIV_C_LOG2 = 5
) (
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic [1:0] clk_select,
  input  wire logic [1:0] edge_select,
  input  wire logic       event_in,
  output logic            tick
);

  import reload_timer_pkg::*;

  // ----------------------------------------------------------------
  // Free prescaler and pin synchroniser.
  // ----------------------------------------------------------------
  logic [PRESCALE_WIDTH-1:0] prescale;
  logic [PRESCALE_WIDTH-1:0] prescale_prev;
  logic                      event_meta;
  logic                      event_sync;
  logic                      event_prev;
  logic                      rise;
  logic                      fall;
  logic                      edge_hit;
  logic [2:0]                div_tick;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      prescale      <= '0;
      prescale_prev <= '0;
    end else begin
      prescale      <= prescale + PRESCALE_WIDTH'(1);
      prescale_prev <= prescale;
    end
  end

  // A divided tick is the falling of a prescaler bit, one cycle wide.
  genvar g;
  for (g = 0; g < 3; g++) begin : g_div
    localparam int BITPOS = (g == 0) ? DIV_A_LOG2 - 1 : (g == 1) ? DIV_B_LOG2 - 1 : DIV_C_LOG2 - 1;
    assign div_tick[g] = prescale_prev[BITPOS] & ~prescale[BITPOS];
  end

  // The first stage is read only by the second, so metastability stays contained.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      event_meta <= 1'b0;
      event_sync <= 1'b0;
      event_prev <= 1'b0;
    end else begin
      event_meta <= event_in;
      event_sync <= event_meta;
      event_prev <= event_sync;
    end
  end

  assign rise     = event_sync & ~event_prev;
  assign fall     = ~event_sync & event_prev;
  assign edge_hit = ((edge_select == EDGE_RISE) & rise) | ((edge_select == EDGE_FALL) & fall) |
                    ((edge_select == EDGE_BOTH) & (rise | fall));

  always_comb begin
    case (clk_select)
      CLKSEL_DIV_A: tick = div_tick[0];
      CLKSEL_DIV_B: tick = div_tick[1];
      CLKSEL_DIV_C: tick = div_tick[2];
      CLKSEL_EVENT: tick = edge_hit;
      default:      tick = 1'b0;
    endcase
  end

endmodule : tick_source

// file: src/reload_down_counter_timer.sv
// Function
// - Internal mode counts selected prescaled clock ticks.
// - Event mode counts valid external input edges.
// - Underflow is the wrap from zero.
// - Period is reload value plus one.
// - Reload mode reloads and keeps counting.
// - One-shot mode stops at first underflow.
// - Underflow raises request usable by transfer service when irq_enable is set.
module reload_down_counter_timer
#(
  parameter int DIV_A_LOG2 = 1,
  parameter int DIV_B_LOG2 = 3,
  parameter int DIV_C_LOG2 = 5
) (
  input  wire logic                                     core_clk,
  input  wire logic                                     reset_n,
  input  wire logic                                     count_enable,
  input  wire logic                                     trigger,
  input  wire logic                                     reload_mode,
  input  wire logic [1:0]                               clk_select,
  input  wire logic [1:0]                               edge_select,
  input  wire logic [reload_timer_pkg::COUNT_WIDTH-1:0] reload_value,
  input  wire logic                                     irq_enable,
  input  wire logic                                     flag_clear,
  input  wire logic                                     event_in,
  output logic [reload_timer_pkg::COUNT_WIDTH-1:0]      count_value,
  output logic                                          running,
  output logic                                          underflow_flag,
  output logic                                          underflow_pulse,
  output logic                                          irq,
  output logic                                          transfer_service_controller_req
);

  import reload_timer_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_COUNT,
    ST_HALT
  } timer_state_t;

  // ----------------------------------------------------------------
  // Internal signals.
  // ----------------------------------------------------------------
  logic         tick;
  logic         enable_prev;
  logic         enable_rise;
  logic         trigger_start;
  logic         start;
  logic         at_zero;
  logic         step;
  logic         wrap;
  logic         wrap_reload;
  logic         wrap_stop;
  count_mode_t  mode;
  timer_state_t state;

  // ----------------------------------------------------------------
  // Count tick source.
  // ----------------------------------------------------------------
  tick_source #(
    .DIV_A_LOG2 (DIV_A_LOG2),
    .DIV_B_LOG2 (DIV_B_LOG2),
    .DIV_C_LOG2 (DIV_C_LOG2)
  ) u_tick_source (
    .core_clk    (core_clk),
    .reset_n     (reset_n),
    .clk_select  (clk_select),
    .edge_select (edge_select),
    .event_in    (event_in),
    .tick        (tick)
  );

  // ----------------------------------------------------------------
  // Enable history.
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      enable_prev <= 1'b0;
    end else begin
      enable_prev <= count_enable;
    end
  end

  // ----------------------------------------------------------------
  // Start decode.
  // ----------------------------------------------------------------
  // An enable that is already high when reset ends still counts as a start, since enable_prev resets low.
  assign mode          = reload_mode ? MODE_RELOAD : MODE_ONE_SHOT;
  assign enable_rise   = count_enable & ~enable_prev;
  assign trigger_start = count_enable & trigger;
  assign start         = enable_rise | trigger_start;

  // ----------------------------------------------------------------
  // Underflow decode.
  // ----------------------------------------------------------------
  assign at_zero       = (count_value == COUNT_ZERO);
  assign step          = running & tick;
  assign wrap          = step & at_zero;
  assign wrap_reload   = wrap & (mode == MODE_RELOAD);
  assign wrap_stop     = wrap & (mode == MODE_ONE_SHOT);

  // ----------------------------------------------------------------
  // Run state.
  // ----------------------------------------------------------------
  // The halt state keeps an expired one-shot apart from a disabled timer; only a new start or a dropped count_enable leaves it.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state   <= ST_IDLE;
      running <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start) begin
            state   <= ST_COUNT;
            running <= 1'b1;
          end
        end
        ST_COUNT: begin
          if (!count_enable) begin
            state   <= ST_IDLE;
            running <= 1'b0;
          end else if (wrap_stop && !start) begin
            state   <= ST_HALT;
            running <= 1'b0;
          end
        end
        ST_HALT: begin
          if (!count_enable) begin
            state   <= ST_IDLE;
            running <= 1'b0;
          end else if (start) begin
            state   <= ST_COUNT;
            running <= 1'b1;
          end
        end
        default: begin
          state   <= ST_IDLE;
          running <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Counter.
  // ----------------------------------------------------------------
  // A start takes priority over a tick, so the first period is always whole.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      count_value <= COUNT_RESET;
    end else if (start) begin
      count_value <= reload_value;
    end else if (wrap_reload) begin
      count_value <= reload_value;
    end else if (step) begin
      count_value <= count_value - COUNT_WIDTH'(1);
    end
  end

  // ----------------------------------------------------------------
  // Underflow reporting.
  // ----------------------------------------------------------------
  // Set wins over clear so an underflow in the clearing cycle is kept.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      underflow_flag <= 1'b0;
    end else if (wrap) begin
      underflow_flag <= 1'b1;
    end else if (flag_clear) begin
      underflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      underflow_pulse <= 1'b0;
    end else begin
      underflow_pulse <= wrap;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt and transfer request.
  // ----------------------------------------------------------------
  // The request follows the gated interrupt, so masking also holds back the transfer service.
  assign irq                             = underflow_flag & irq_enable;
  assign transfer_service_controller_req = irq;

endmodule : reload_down_counter_timer

// file: test/event_source.sv
module event_source (
  input  wire logic core_clk,
  input  wire logic fire,
  output logic      event_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial event_in = 1'b0;
  // Each request flips the pin, so rising and falling edges alternate.
  always @(posedge core_clk) begin
    if (fire) event_in <= ~event_in;
  end
endmodule : event_source

// file: test/timer_monitor.sv
module timer_monitor
  import reload_timer_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic        count_enable,
  input wire logic        trigger,
  input wire logic        reload_mode,
  input wire logic [15:0] reload_value,
  input wire logic        irq_enable,
  input wire logic        flag_clear,
  input wire logic [15:0] count_value,
  input wire logic        running,
  input wire logic        underflow_flag,
  input wire logic        underflow_pulse,
  input wire logic        irq,
  input wire logic        transfer_service_controller_req
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_irq_gate: assert property (irq == (underflow_flag & irq_enable)) else $error("irq gate wrong");
  a_req_mirror: assert property (transfer_service_controller_req == irq) else $error("req wrong");
  a_flag_cause: assert property ($rose(underflow_flag) |-> underflow_pulse) else $error("flag no wrap");
  a_flag_hold: assert property (underflow_flag && !flag_clear |=> underflow_flag) else $error("flag lost");
  a_start_load: assert property ($rose(count_enable) |=> running && count_value == $past(reload_value))
    else $error("start load wrong");
  a_wrap_reload: assert property (underflow_pulse && reload_mode |-> running && count_value == reload_value)
    else $error("reload wrong");
  a_oneshot_stop: assert property (underflow_pulse && !reload_mode |-> !running && count_value == 16'hffff)
    else $error("one-shot wrong");
  a_count_step: assert property (running && $past(running) && !$past(trigger) && !underflow_pulse &&
    count_value != $past(count_value) |-> count_value == $past(count_value) - 16'h0001) else $error("bad step");
endmodule : timer_monitor

// file: test/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import reload_timer_pkg::*;
  logic core_clk = 0, reset_n = 0, count_enable = 0, trigger = 0, reload_mode = 0;
  logic irq_enable = 0, flag_clear = 0, fire = 0;
  logic [1:0] clk_select = 2'h0, edge_select = 2'h0;
  logic [15:0] reload_value = 16'h0000, count_value;
  logic event_in, running, underflow_flag, underflow_pulse, irq, transfer_service_controller_req;
  int err_total = 0, check_count = 0, cyc = 0;
  always #50 core_clk = ~core_clk;
  reload_down_counter_timer u_reload_down_counter_timer (
    .core_clk                        (core_clk),
    .reset_n                         (reset_n),
    .count_enable                    (count_enable),
    .trigger                         (trigger),
    .reload_mode                     (reload_mode),
    .clk_select                      (clk_select),
    .edge_select                     (edge_select),
    .reload_value                    (reload_value),
    .irq_enable                      (irq_enable),
    .flag_clear                      (flag_clear),
    .event_in                        (event_in),
    .count_value                     (count_value),
    .running                         (running),
    .underflow_flag                  (underflow_flag),
    .underflow_pulse                 (underflow_pulse),
    .irq                             (irq),
    .transfer_service_controller_req (transfer_service_controller_req)
  );
  event_source u_event_source (.core_clk(core_clk), .fire(fire), .event_in(event_in));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wait_pulse(output int n);
    @(negedge core_clk);
    n = 1;
    while (underflow_pulse !== 1'b1 && n < 5000) begin
      @(negedge core_clk);
      n++;
    end
  endtask : wait_pulse
  task automatic restart(input logic [1:0] sel, input logic mode, input logic [15:0] n);
    @(negedge core_clk);
    count_enable = 0;
    clk_select = sel;
    reload_mode = mode;
    reload_value = n;
    flag_clear = 1;
    @(negedge core_clk);
    flag_clear = 0;
    count_enable = 1;
  endtask : restart
  task automatic t_reload;
    int n;
    for (int s = 0; s < 3; s++) begin
      restart(s[1:0], 1'b1, 16'h0002);
      wait_pulse(n);
      check(count_value, 16'h0002, "reloaded count");
      wait_pulse(n);
      check(16'(n), 16'(3 << (2 * s + 1)), "period");
    end
    $display("t_reload done");
  endtask : t_reload
  task automatic t_oneshot;
    int n;
    irq_enable = 0;
    restart(2'h0, 1'b0, 16'h0001);
    wait_pulse(n);
    check(count_value, 16'hffff, "wrap value");
    check(irq, 1'b0, "masked irq");
    irq_enable = 1;
    #1 check(transfer_service_controller_req, 1'b1, "request");
    repeat (10) @(negedge core_clk);
    check(running, 1'b0, "stopped");
    trigger = 1;
    @(negedge core_clk);
    trigger = 0;
    check(count_value, 16'h0001, "restart load");
    flag_clear = 1;
    @(negedge core_clk);
    flag_clear = 0;
    check(underflow_flag, 1'b0, "cleared flag");
    $display("t_oneshot done");
  endtask : t_oneshot
  task automatic t_event;
    edge_select = 2'h1;
    restart(2'h3, 1'b1, 16'h0001);
    for (int i = 1; i <= 3; i++) begin
      fire = 1;
      @(negedge core_clk);
      fire = 0;
      repeat (6) @(negedge core_clk);
      if (i == 2) check(underflow_flag, 1'b0, "one rising edge");
    end
    check(underflow_flag, 1'b1, "two rising edges");
    $display("t_event done");
  endtask : t_event
  task automatic event_step;
    fire = 1;
    @(negedge core_clk);
    fire = 0;
    repeat (6) @(negedge core_clk);
  endtask : event_step
  task automatic t_edges;
    edge_select = 2'h2;
    restart(2'h3, 1'b1, 16'h0001);
    event_step();
    check(count_value, 16'h0000, "falling edge counted");
    event_step();
    check(count_value, 16'h0000, "rising edge ignored");
    edge_select = 2'h3;
    event_step();
    check(underflow_flag, 1'b1, "both edges wrap");
    check(count_value, 16'h0001, "both edges reload");
    edge_select = 2'h0;
    event_step();
    check(count_value, 16'h0001, "no edge selected");
    $display("t_edges done");
  endtask : t_edges
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    repeat (6) @(negedge core_clk);
    reset_n = 1;
    check(count_value, COUNT_RESET, "reset count");
    t_reload();
    t_oneshot();
    t_event();
    t_edges();
    complete_run();
  end
endmodule : tb_top
bind reload_down_counter_timer timer_monitor u_timer_monitor (
  .core_clk                        (core_clk),
  .reset_n                         (reset_n),
  .count_enable                    (count_enable),
  .trigger                         (trigger),
  .reload_mode                     (reload_mode),
  .reload_value                    (reload_value),
  .irq_enable                      (irq_enable),
  .flag_clear                      (flag_clear),
  .count_value                     (count_value),
  .running                         (running),
  .underflow_flag                  (underflow_flag),
  .underflow_pulse                 (underflow_pulse),
  .irq                             (irq),
  .transfer_service_controller_req (transfer_service_controller_req)
);
